// ---- mcu_mem_pkg.sv ----
// constants, register map and state types for the memory access control block
// assumes a single 200 MHz clock and an 8051-style core that issues requests
package mcu_mem_pkg;
    // ********************************************************
    // internal memory map
    // ********************************************************
    localparam logic [7:0] BANK_BASE = 8'h00;
    localparam logic [7:0] BANK_LAST = 8'h1F;
    localparam logic [7:0] BIT_AREA_BASE = 8'h20;
    localparam int BIT_AREA_BYTES = 16;
    localparam int SCRATCH_BYTES = 208;
    localparam logic [7:0] UPPER_BASE = 8'h80;
    localparam int UPPER_BIT = 7;

    // ********************************************************
    // special function register offsets and resets
    // ********************************************************
    localparam logic [7:0] PTR_SELECT_ADDR = 8'h86;
    localparam logic [7:0] POWER_CONTROL_FLAGS_ADDR = 8'h87;
    localparam logic [7:0] CODE_WAIT_STATES_ADDR = 8'h92;
    localparam logic [7:0] PTR0_UPPER_ADDR_ADDR = 8'h93;
    localparam logic [7:0] PTR1_UPPER_ADDR_ADDR = 8'h95;
    localparam logic [7:0] PORT_TWO_LATCH_ADDR = 8'hA0;
    localparam logic [7:0] INDIRECT_UPPER_ADDR_ADDR = 8'hEA;
    localparam logic [7:0] POWER_CONTROL_FLAGS_RESET = 8'h00;
    localparam logic [2:0] CODE_WAIT_STATES_RESET = 3'h7;
    localparam logic [7:0] UPPER_ADDR_RESET = 8'h00;
    localparam logic [7:0] PORT_TWO_LATCH_RESET = 8'hFF;
    localparam int SERIAL_MODE_BIT = 7;
    localparam int PROGRAM_WRITE_ENABLE_BIT = 4;
    localparam int PTR_SELECT_BIT = 0;

    // ********************************************************
    // timing
    // ********************************************************
    localparam logic [3:0] CODE_WAIT_MIN = 4'h4;
    localparam logic [3:0] DATA_STROBE_MD_MIN = 4'h2;
    localparam logic [3:0] CODE_WR_MIN_CLKS = 4'h5;

    // ********************************************************
    // state types
    // ********************************************************
    typedef enum logic [2:0] {
        ACC_IDLE = 3'b001,
        ACC_MERGE = 3'b010,
        ACC_DONE = 3'b100
    } acc_state_t;

    typedef enum logic [2:0] {
        XF_IDLE = 3'b001,
        XF_STROBE = 3'b010,
        XF_DONE = 3'b100
    } xfer_state_t;
endpackage : mcu_mem_pkg

// ---- iram_byte_mem.sv ----
// 256 x 8 internal data memory with registered read data
// assumes one write port and one read port on the same clock
module iram_byte_mem (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // write port
    input wire logic we,
    input wire logic [7:0] waddr,
    input wire logic [7:0] wdata,
    // read port
    input wire logic [7:0] raddr,
    output logic [7:0] rdata_reg
);
    logic [7:0] mem [0:255];

    // array kept without reset so it maps onto plain ram
    always_ff @(posedge clock) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // read data from a register, one cycle after the address
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= mem[raddr];
        end
    end
endmodule : iram_byte_mem

// ---- mcu_memory_access_control.sv ----
// internal ram / sfr space decode, address extension and code/data strobes
// assumes the core holds fetch and movx requests until their done pulse
// ********************************************************
// top module
// ********************************************************
// How it works
// - bytes 0x00-0x1F are four eight-register banks
// - sixteen bytes at 0x20 hold 128 bits
// - 208 scratch bytes above the bit area
// - indirect 0x80-0xFF reaches upper ram
// - direct 0x80-0xFF reaches sfr space
// - only sfr at nibble 0 or 8 bit-addressable
// - program write enable gates code write strobe
// - pointer store writes accumulator into code
// - register store uses port two high byte
// - code read takes wait field plus one, at least five clocks
// - wait field affects only code reads
// - code write width follows data strobe width
// - code writes use at least four waits
// - three extension registers give upper byte
// - extension registers reset to zero
// - pointer store upper byte from pointer extension
// - register store upper byte from indirect extension
// - select bit chooses pointer zero or one
module mcu_memory_access_control (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // internal ram and sfr access from the core
    input wire logic acc_req,
    input wire logic acc_we,
    input wire logic acc_indirect,
    input wire logic acc_bit,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_wdata,
    output logic acc_done,
    output logic [7:0] acc_rdata_reg,
    // sfrs that live outside this block
    output logic [7:0] sfr_ext_addr_reg,
    output logic sfr_ext_we_reg,
    output logic [7:0] sfr_ext_wdata_reg,
    input wire logic [7:0] sfr_ext_rdata,
    // core state used by movx
    input wire logic [15:0] data_pointer_zero,
    input wire logic [15:0] data_pointer_one,
    input wire logic [7:0] movx_ri,
    input wire logic [7:0] accumulator,
    input wire logic [2:0] data_strobe_width,
    // code read request (fetch or movc)
    input wire logic fetch_req,
    input wire logic [15:0] fetch_addr,
    output logic fetch_done,
    output logic [7:0] fetch_rdata_reg,
    // movx request
    input wire logic movx_req,
    input wire logic movx_write,
    input wire logic movx_use_dptr,
    output logic movx_done,
    output logic [7:0] movx_rdata_reg,
    // code memory
    output logic [15:0] code_addr_reg,
    output logic code_rd_reg,
    output logic code_wr_reg,
    output logic [7:0] code_wdata_reg,
    input wire logic [7:0] code_rdata,
    // data memory
    output logic [23:0] data_addr_reg,
    output logic data_rd_reg,
    output logic data_wr_reg,
    output logic [7:0] data_wdata_reg,
    input wire logic [7:0] data_rdata
);
    // ********************************************************
    // helper functions
    // ********************************************************
    // byte that a bit address lives in
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        logic [7:0] r;
        r = 8'h00;
        if (b[mcu_mem_pkg::UPPER_BIT]) begin
            r = {b[7:3], 3'h0};
        end else begin
            r = mcu_mem_pkg::BIT_AREA_BASE + {4'h0, b[6:3]};
        end
        return r;
    endfunction : bit_byte

    function automatic logic [7:0] merge_bit(input logic [7:0] old, input logic [2:0] pos,
                                             input logic val);
        logic [7:0] r;
        r = old;
        r[pos] = val;
        return r;
    endfunction : merge_bit

    // unused low codes are pulled up to the shortest legal time
    function automatic logic [3:0] code_read_clks(input logic [2:0] w);
        logic [3:0] e;
        e = {1'b0, w};
        if (e < mcu_mem_pkg::CODE_WAIT_MIN) begin
            e = mcu_mem_pkg::CODE_WAIT_MIN;
        end
        return e + 4'h1;
    endfunction : code_read_clks

    function automatic logic [3:0] data_strobe_clks(input logic [2:0] md);
        logic [3:0] e;
        e = {1'b0, md};
        if (e < mcu_mem_pkg::DATA_STROBE_MD_MIN) begin
            e = mcu_mem_pkg::DATA_STROBE_MD_MIN;
        end
        return e + 4'h1;
    endfunction : data_strobe_clks

    // ********************************************************
    // own special function registers
    // ********************************************************
    logic [7:0] power_control_flags_reg;
    logic [2:0] code_wait_states_reg;
    logic [7:0] ptr0_upper_addr_reg;
    logic [7:0] ptr1_upper_addr_reg;
    logic [7:0] indirect_upper_addr_reg;
    logic sel_reg;
    logic [7:0] port_two_latch_reg;
    logic program_write_enable;
    assign program_write_enable = power_control_flags_reg[mcu_mem_pkg::PROGRAM_WRITE_ENABLE_BIT];

    // ********************************************************
    // internal ram / sfr access
    // ********************************************************
    mcu_mem_pkg::acc_state_t acc_state_reg;
    mcu_mem_pkg::acc_state_t acc_state_next;
    logic lat_we_reg;
    logic lat_bit_reg;
    logic lat_to_ram_reg;
    logic [2:0] lat_pos_reg;
    logic [7:0] lat_byte_reg;
    logic [7:0] lat_wdata_reg;
    logic [7:0] ram_rdata;
    logic acc_take;
    logic [7:0] acc_byte;
    logic acc_to_ram;
    logic [7:0] sfr_rdata;
    logic [7:0] old_byte;
    logic [7:0] new_byte;
    logic ram_we;
    logic sfr_we;
    logic own_sfr;

    assign acc_take = acc_req && (acc_state_reg == mcu_mem_pkg::ACC_IDLE);
    assign acc_byte = acc_bit ? bit_byte(acc_addr) : acc_addr;
    // banks, bit area and scratch are always ram; upper half by mode
    assign acc_to_ram = !acc_byte[mcu_mem_pkg::UPPER_BIT]
        || (acc_indirect && !acc_bit);

    // own sfr read mux; others are served outside
    always_comb begin
        own_sfr = 1'b1;
        case (lat_byte_reg)
            mcu_mem_pkg::POWER_CONTROL_FLAGS_ADDR: sfr_rdata = power_control_flags_reg;
            mcu_mem_pkg::CODE_WAIT_STATES_ADDR: sfr_rdata = {5'h00, code_wait_states_reg};
            mcu_mem_pkg::PTR0_UPPER_ADDR_ADDR: sfr_rdata = ptr0_upper_addr_reg;
            mcu_mem_pkg::PTR1_UPPER_ADDR_ADDR: sfr_rdata = ptr1_upper_addr_reg;
            mcu_mem_pkg::INDIRECT_UPPER_ADDR_ADDR: sfr_rdata = indirect_upper_addr_reg;
            mcu_mem_pkg::PTR_SELECT_ADDR: sfr_rdata = {7'h00, sel_reg};
            mcu_mem_pkg::PORT_TWO_LATCH_ADDR: sfr_rdata = port_two_latch_reg;
            default: begin
                sfr_rdata = sfr_ext_rdata;
                own_sfr = 1'b0;
            end
        endcase
    end

    // read-modify-write merge happens in the second cycle
    assign old_byte = lat_to_ram_reg ? ram_rdata : sfr_rdata;
    assign new_byte = lat_bit_reg ? merge_bit(old_byte, lat_pos_reg, lat_wdata_reg[0]) : lat_wdata_reg;
    assign ram_we = (acc_state_reg == mcu_mem_pkg::ACC_MERGE) && lat_we_reg && lat_to_ram_reg;
    assign sfr_we = (acc_state_reg == mcu_mem_pkg::ACC_MERGE) && lat_we_reg && !lat_to_ram_reg;
    assign acc_done = (acc_state_reg == mcu_mem_pkg::ACC_DONE);

    iram_byte_mem u_iram (
        .clock(clock),
        .rstn(rstn),
        .we(ram_we),
        .waddr(lat_byte_reg),
        .wdata(new_byte),
        .raddr(acc_byte),
        .rdata_reg(ram_rdata)
    );

    // access sequencer: take, merge, done
    always_comb begin
        case (acc_state_reg)
            mcu_mem_pkg::ACC_IDLE: acc_state_next = acc_req ? mcu_mem_pkg::ACC_MERGE : mcu_mem_pkg::ACC_IDLE;
            mcu_mem_pkg::ACC_MERGE: acc_state_next = mcu_mem_pkg::ACC_DONE;
            mcu_mem_pkg::ACC_DONE: acc_state_next = mcu_mem_pkg::ACC_IDLE;
            default: acc_state_next = mcu_mem_pkg::ACC_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acc_state_reg <= mcu_mem_pkg::ACC_IDLE;
            lat_we_reg <= 1'b0;
            lat_bit_reg <= 1'b0;
            lat_to_ram_reg <= 1'b0;
            lat_pos_reg <= 3'h0;
            lat_byte_reg <= 8'h00;
            lat_wdata_reg <= 8'h00;
        end else begin
            acc_state_reg <= acc_state_next;
            if (acc_take) begin
                lat_we_reg <= acc_we;
                lat_bit_reg <= acc_bit;
                lat_to_ram_reg <= acc_to_ram;
                lat_pos_reg <= acc_addr[2:0];
                lat_byte_reg <= acc_byte;
                lat_wdata_reg <= acc_wdata;
            end
        end
    end

    // read answer and outside sfr write, both from flops
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acc_rdata_reg <= 8'h00;
            sfr_ext_we_reg <= 1'b0;
            sfr_ext_wdata_reg <= 8'h00;
            sfr_ext_addr_reg <= 8'h00;
        end else begin
            sfr_ext_we_reg <= sfr_we && !own_sfr;
            sfr_ext_wdata_reg <= new_byte;
            if (acc_take) begin
                sfr_ext_addr_reg <= acc_byte;
            end
            if (acc_state_reg == mcu_mem_pkg::ACC_MERGE) begin
                acc_rdata_reg <= lat_bit_reg ? {7'h00, old_byte[lat_pos_reg]} : old_byte;
            end
        end
    end

    // own sfr writes; unimplemented bits are not stored
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            power_control_flags_reg <= mcu_mem_pkg::POWER_CONTROL_FLAGS_RESET;
            code_wait_states_reg <= mcu_mem_pkg::CODE_WAIT_STATES_RESET;
            ptr0_upper_addr_reg <= mcu_mem_pkg::UPPER_ADDR_RESET;
            ptr1_upper_addr_reg <= mcu_mem_pkg::UPPER_ADDR_RESET;
            indirect_upper_addr_reg <= mcu_mem_pkg::UPPER_ADDR_RESET;
            sel_reg <= 1'b0;
            port_two_latch_reg <= mcu_mem_pkg::PORT_TWO_LATCH_RESET;
        end else if (sfr_we) begin
            case (lat_byte_reg)
                mcu_mem_pkg::POWER_CONTROL_FLAGS_ADDR: begin
                    power_control_flags_reg <= new_byte & 8'h90;
                end
                mcu_mem_pkg::CODE_WAIT_STATES_ADDR: code_wait_states_reg <= new_byte[2:0];
                mcu_mem_pkg::PTR0_UPPER_ADDR_ADDR: ptr0_upper_addr_reg <= new_byte;
                mcu_mem_pkg::PTR1_UPPER_ADDR_ADDR: ptr1_upper_addr_reg <= new_byte;
                mcu_mem_pkg::INDIRECT_UPPER_ADDR_ADDR: indirect_upper_addr_reg <= new_byte;
                mcu_mem_pkg::PTR_SELECT_ADDR: sel_reg <= new_byte[mcu_mem_pkg::PTR_SELECT_BIT];
                mcu_mem_pkg::PORT_TWO_LATCH_ADDR: port_two_latch_reg <= new_byte;
                default: ;
            endcase
        end
    end

    // ********************************************************
    // code and data memory transfers
    // ********************************************************
    mcu_mem_pkg::xfer_state_t xf_state_reg;
    logic xk_fetch_reg;
    logic [3:0] cnt_reg;
    logic grant_fetch;
    logic grant_movx;
    logic [15:0] dptr_active;
    logic [7:0] dpx_active;
    logic [23:0] movx_addr;
    logic to_code_wr;
    logic [3:0] data_len;
    logic [3:0] code_wr_len;
    logic [3:0] grant_len;

    assign grant_fetch = fetch_req && (xf_state_reg == mcu_mem_pkg::XF_IDLE);
    assign grant_movx = movx_req && !fetch_req && (xf_state_reg == mcu_mem_pkg::XF_IDLE);
    assign dptr_active = sel_reg ? data_pointer_one : data_pointer_zero;
    assign dpx_active = sel_reg ? ptr1_upper_addr_reg : ptr0_upper_addr_reg;
    // pointer form or register form of the 24-bit address
    assign movx_addr = movx_use_dptr ? {dpx_active, dptr_active}
        : {indirect_upper_addr_reg, port_two_latch_reg, movx_ri};
    assign to_code_wr = movx_write && program_write_enable;
    assign data_len = data_strobe_clks(data_strobe_width);
    // code write width comes from the data strobe setting, floored
    assign code_wr_len = (data_len < mcu_mem_pkg::CODE_WR_MIN_CLKS) ? mcu_mem_pkg::CODE_WR_MIN_CLKS
        : data_len;
    assign grant_len = grant_fetch ? code_read_clks(code_wait_states_reg)
        : (to_code_wr ? code_wr_len : data_len);
    assign fetch_done = (xf_state_reg == mcu_mem_pkg::XF_DONE) && xk_fetch_reg;
    assign movx_done = (xf_state_reg == mcu_mem_pkg::XF_DONE) && !xk_fetch_reg;

    // strobe sequencer: grant, hold strobe for its length, done
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            xf_state_reg <= mcu_mem_pkg::XF_IDLE;
            xk_fetch_reg <= 1'b0;
            cnt_reg <= 4'h0;
            code_rd_reg <= 1'b0;
            code_wr_reg <= 1'b0;
            data_rd_reg <= 1'b0;
            data_wr_reg <= 1'b0;
        end else begin
            case (xf_state_reg)
                mcu_mem_pkg::XF_IDLE: begin
                    if (grant_fetch || grant_movx) begin
                        xf_state_reg <= mcu_mem_pkg::XF_STROBE;
                        xk_fetch_reg <= grant_fetch;
                        cnt_reg <= grant_len - 4'h1;
                        code_rd_reg <= grant_fetch;
                        code_wr_reg <= grant_movx && to_code_wr;
                        data_rd_reg <= grant_movx && !movx_write;
                        data_wr_reg <= grant_movx && movx_write && !to_code_wr;
                    end
                end
                mcu_mem_pkg::XF_STROBE: begin
                    if (cnt_reg == 4'h0) begin
                        xf_state_reg <= mcu_mem_pkg::XF_DONE;
                        code_rd_reg <= 1'b0;
                        code_wr_reg <= 1'b0;
                        data_rd_reg <= 1'b0;
                        data_wr_reg <= 1'b0;
                    end else begin
                        cnt_reg <= cnt_reg - 4'h1;
                    end
                end
                mcu_mem_pkg::XF_DONE: xf_state_reg <= mcu_mem_pkg::XF_IDLE;
                default: xf_state_reg <= mcu_mem_pkg::XF_IDLE;
            endcase
        end
    end

    // addresses and data held for the whole strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            code_addr_reg <= 16'h0000;
            code_wdata_reg <= 8'h00;
            data_addr_reg <= 24'h000000;
            data_wdata_reg <= 8'h00;
            fetch_rdata_reg <= 8'h00;
            movx_rdata_reg <= 8'h00;
        end else begin
            if (grant_fetch || grant_movx) begin
                code_addr_reg <= grant_fetch ? fetch_addr : movx_addr[15:0];
                data_addr_reg <= movx_addr;
                code_wdata_reg <= accumulator;
                data_wdata_reg <= accumulator;
            end
            // sampled on the last strobe cycle
            if (code_rd_reg && cnt_reg == 4'h0) begin
                fetch_rdata_reg <= code_rdata;
            end
            if (data_rd_reg && cnt_reg == 4'h0) begin
                movx_rdata_reg <= data_rdata;
            end
        end
    end

    // ********************************************************
    // checks
    // ********************************************************
    logic [3:0] run_reg;
    logic [3:0] exp_reg;
    logic any_strobe;
    assign any_strobe = code_rd_reg || code_wr_reg || data_rd_reg || data_wr_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            run_reg <= 4'h0;
            exp_reg <= 4'h0;
        end else begin
            run_reg <= any_strobe ? run_reg + 4'h1 : 4'h0;
            if (grant_fetch || grant_movx) begin
                exp_reg <= grant_len;
            end
        end
    end

    sequence s_ptr_store;
        grant_movx && movx_use_dptr;
    endsequence
    sequence s_reg_store;
        grant_movx && !movx_use_dptr;
    endsequence
    sequence s_direct_high;
        acc_take && !acc_indirect && !acc_bit && acc_addr[7];
    endsequence

    property p_code_wr_gate;
        @(posedge clock) disable iff (!rstn) code_wr_reg |-> program_write_enable && !data_wr_reg;
    endproperty
    a_code_wr_gate: assert property (p_code_wr_gate) else $error("code write without enable");
    property p_store_to_data;
        @(posedge clock) disable iff (!rstn)
            grant_movx && movx_write && !program_write_enable |=> data_wr_reg && !code_wr_reg;
    endproperty
    a_store_to_data: assert property (p_store_to_data) else $error("store missed data memory");
    property p_code_rd_len;
        @(posedge clock) disable iff (!rstn)
            $fell(code_rd_reg) |-> run_reg >= 4'h5 && run_reg <= 4'h8 && run_reg == exp_reg;
    endproperty
    a_code_rd_len: assert property (p_code_rd_len) else $error("code read length wrong");
    property p_code_wr_len;
        @(posedge clock) disable iff (!rstn)
            $fell(code_wr_reg) |-> run_reg >= 4'h5 && run_reg == exp_reg;
    endproperty
    a_code_wr_len: assert property (p_code_wr_len) else $error("code write length wrong");
    property p_ptr_upper;
        @(posedge clock) disable iff (!rstn)
            s_ptr_store |=> data_addr_reg == {$past(dpx_active), $past(dptr_active)};
    endproperty
    a_ptr_upper: assert property (p_ptr_upper) else $error("pointer address wrong");
    property p_reg_upper;
        @(posedge clock) disable iff (!rstn)
            s_reg_store |=> data_addr_reg[23:8]
                == {$past(indirect_upper_addr_reg), $past(port_two_latch_reg)};
    endproperty
    a_reg_upper: assert property (p_reg_upper) else $error("register address wrong");
    property p_direct_sfr;
        @(posedge clock) disable iff (!rstn) s_direct_high |=> !ram_we ##1 acc_done;
    endproperty
    a_direct_sfr: assert property (p_direct_sfr) else $error("direct high hit ram");
    property p_indirect_ram;
        @(posedge clock) disable iff (!rstn)
            acc_take && acc_indirect && acc_we && !acc_bit |=> ram_we && lat_byte_reg == $past(acc_addr);
    endproperty
    a_indirect_ram: assert property (p_indirect_ram) else $error("indirect write missed ram");
    property p_bit_sfr;
        @(posedge clock) disable iff (!rstn)
            acc_take && acc_bit && acc_addr[7] |=> lat_byte_reg[2:0] == 3'h0 && !lat_to_ram_reg;
    endproperty
    a_bit_sfr: assert property (p_bit_sfr) else $error("bit sfr not aligned");
endmodule : mcu_memory_access_control

// ---- mem_partner.sv ----
// code and data memory model standing on the far side of the access block
// assumes registered strobes and addresses coming from the block
module mem_partner (
    // strobes and addresses from the block
    input wire logic clock,
    input wire logic [15:0] code_addr,
    input wire logic code_rd,
    input wire logic code_wr,
    input wire logic [7:0] code_wdata,
    input wire logic [23:0] data_addr,
    input wire logic data_rd,
    // read data back to the block
    output logic [7:0] code_rdata,
    output logic [7:0] data_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] code_mem [256];
    // outside a strobe the lines show an inverted pattern so stale data never looks right
    assign code_rdata = code_rd ? code_mem[code_addr[7:0]] : ~code_addr[7:0];
    assign data_rdata = data_rd ? data_addr[7:0] ^ 8'h3C : ~data_addr[15:8];
    // code memory takes a byte on the write strobe
    always @(posedge clock) if (code_wr) code_mem[code_addr[7:0]] <= code_wdata;
    initial for (int i = 0; i < 256; i++) code_mem[i] = 8'(i) ^ 8'hA5;
endmodule : mem_partner

// ---- mcu_memory_access_control_tb_top.sv ----
// self-checking bench for the memory access control block with a memory model
// assumes the block answers with the hand-over timing on a 200 MHz clock
module mcu_memory_access_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = '0, rstn = '0, acc_req = '0, acc_we = '0, acc_indirect = '0, acc_bit = '0;
    logic fetch_req = '0, movx_req = '0, movx_write = '0, movx_use_dptr = '0, cw, dw;
    logic [7:0] acc_addr = '0, acc_wdata = '0, sfr_ext_rdata = '0, movx_ri = '0, accumulator = '0;
    logic [15:0] data_pointer_zero = '0, data_pointer_one = '0, fetch_addr = '0;
    logic [2:0] data_strobe_width = 3'h7;
    logic acc_done, fetch_done, movx_done, code_rd_reg, code_wr_reg, data_rd_reg, data_wr_reg;
    logic [7:0] acc_rdata_reg, fetch_rdata_reg, code_wdata_reg, code_rdata, data_rdata, cmem [256];
    logic [15:0] code_addr_reg;
    logic [23:0] data_addr_reg, adr, ea;
    int miscompares = 0, n_compared = 0, cycles = 0, seed = 32'h41df, wt = 7, n, md;
    mcu_memory_access_control uut (.clock, .rstn, .acc_req, .acc_we, .acc_indirect, .acc_bit,
        .acc_addr, .acc_wdata, .acc_done, .acc_rdata_reg, .sfr_ext_addr_reg(), .sfr_ext_we_reg(),
        .sfr_ext_wdata_reg(), .sfr_ext_rdata, .data_pointer_zero, .data_pointer_one, .movx_ri,
        .accumulator, .data_strobe_width, .fetch_req, .fetch_addr, .fetch_done, .fetch_rdata_reg,
        .movx_req, .movx_write, .movx_use_dptr, .movx_done, .movx_rdata_reg(), .code_addr_reg,
        .code_rd_reg, .code_wr_reg, .code_wdata_reg, .code_rdata, .data_addr_reg, .data_rd_reg,
        .data_wr_reg, .data_wdata_reg(), .data_rdata);
    mem_partner far (.clock, .code_addr(code_addr_reg), .code_rd(code_rd_reg),
        .code_wr(code_wr_reg), .code_wdata(code_wdata_reg), .data_addr(data_addr_reg),
        .data_rd(data_rd_reg), .code_rdata, .data_rdata);
    always #2.5 clock = ~clock;
    // a hang counts as a mismatch and ends the run
    always @(posedge clock) if (++cycles > 5000) begin
        miscompares++;
        complete_run();
    end
    task automatic complete_run;
        if (miscompares == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one ram or sfr access, request held one edge
    task automatic t(input logic we, ind, bt, input logic [7:0] a, d, e);
        int k;
        @(negedge clock);
        {acc_req, acc_we, acc_indirect, acc_bit, acc_addr, acc_wdata} = {1'h1, we, ind, bt, a, d};
        sfr_ext_rdata = 8'($random(seed));
        @(negedge clock);
        acc_req = 1'h0;
        for (k = 0; k < 6 && acc_done !== 1'h1; k++) @(negedge clock);
        check(acc_done, 1'h1);
        if (!we) check(acc_rdata_reg, e);
    endtask : t
    // code read: count strobe cycles, compare data
    task automatic fetch(input logic [15:0] a);
        int k;
        n = 0;
        @(negedge clock);
        {fetch_req, fetch_addr} = {1'h1, a};
        for (k = 0; k < 20 && fetch_done !== 1'h1; k++) begin
            @(negedge clock);
            n += int'(code_rd_reg === 1'h1);
        end
        fetch_req = 1'h0;
        check(24'(n), (wt < 4) ? 24'h5 : 24'(wt + 1));
        check(fetch_rdata_reg, cmem[a[7:0]]);
    endtask : fetch
    // movx store; request held until done
    task automatic movx(input logic dp);
        int k;
        {n, cw, dw} = '0;
        @(negedge clock);
        {movx_req, movx_write, movx_use_dptr} = {1'h1, 1'h1, dp};
        for (k = 0; k < 30 && movx_done !== 1'h1; k++) begin
            @(negedge clock);
            {cw, dw} = {cw | code_wr_reg, dw | data_wr_reg};
            n += int'(code_wr_reg | data_wr_reg);
            if (code_wr_reg | data_wr_reg) adr = code_wr_reg ? 24'(code_addr_reg) : data_addr_reg;
        end
        movx_req = 1'h0;
    endtask : movx
    initial begin
        for (int i = 0; i < 256; i++) cmem[i] = 8'(i) ^ 8'hA5;
        repeat (5) @(negedge clock);
        rstn = 1'h1;
        t(0, 0, 0, 8'h87, 8'h00, 8'h00);
        t(0, 0, 0, 8'h92, 8'h00, 8'h07);
        t(0, 0, 0, 8'h93, 8'h00, 8'h00);
        t(0, 0, 0, 8'h95, 8'h00, 8'h00);
        t(0, 0, 0, 8'hEA, 8'h00, 8'h00);
        t(1, 1, 0, 8'h93, 8'h66, 8'h00);
        t(1, 0, 0, 8'h93, 8'h12, 8'h00);
        t(0, 0, 0, 8'h93, 8'h00, 8'h12);
        t(0, 1, 0, 8'h93, 8'h00, 8'h66);
        t(1, 0, 0, 8'h1F, 8'hC3, 8'h00);
        t(0, 1, 0, 8'h1F, 8'h00, 8'hC3);
        t(1, 1, 0, 8'h2F, 8'h00, 8'h00);
        t(1, 0, 1, 8'h7F, 8'h01, 8'h00);
        t(0, 1, 0, 8'h2F, 8'h00, 8'h80);
        t(1, 0, 0, 8'h7F, 8'h3E, 8'h00);
        t(0, 1, 0, 8'h7F, 8'h00, 8'h3E);
        t(1, 0, 1, 8'hA3, 8'h00, 8'h00);
        t(0, 0, 0, 8'hA0, 8'h00, 8'hF7);
        t(1, 0, 0, 8'h95, 8'h4B, 8'h00);
        t(1, 0, 0, 8'hEA, 8'hD2, 8'h00);
        t(1, 0, 0, 8'h86, 8'h01, 8'h00);
        // every wait code, the unused ones included
        for (wt = 0; wt < 8; wt++) begin
            t(1, 0, 0, 8'h92, 8'(wt), 8'h00);
            fetch(16'($random(seed)));
        end
        wt = 7;
        // both store forms, program writes off then on
        for (int i = 0; i < 4; i++) begin
            t(1, 0, 0, 8'h87, {3'h0, 1'(i >> 1), 4'h0}, 8'h00);
            {data_pointer_zero, data_pointer_one, movx_ri, accumulator} = {$random(seed), $random(seed)};
            data_strobe_width = 3'($random(seed));
            md = (data_strobe_width < 2) ? 3 : data_strobe_width + 1;
            ea = i[0] ? {8'h4B, data_pointer_one} : {8'hD2, 8'hF7, movx_ri};
            movx(i[0]);
            check({cw, dw}, i[1] ? 2'b10 : 2'b01);
            check(adr, i[1] ? {8'h00, ea[15:0]} : ea);
            check(24'(n), (i[1] && md < 5) ? 24'h5 : 24'(md));
            if (i[1]) cmem[ea[7:0]] = accumulator;
            fetch(ea[15:0]);
        end
        complete_run();
    end
endmodule : mcu_memory_access_control_tb_top
